// *** src/cal_pkg.sv ***
// package of constants for the converter core calibration sequencer
// Operation
// - foreground calibration forces every channel to mid-code
// - six cores; a,b,c,d served by 0,1,4,5
// - quad: spare 2 covers 0/1, 3 covers 4/5
// - dual and single variants use spare 2 only
// - foreground calibration runs automatically after reset
// - trigger from pin or software bit, selectable
// - background mode never interrupts output data
// - background rotation repeats without end
// - only one core calibrates at any time
// - background calibration uses internal reference, not inputs
// - trims reset to factory values, read and writable
package cal_pkg;
	localparam int num_cores = 6;
	localparam int num_channels = 4;
	localparam int sample_width = 9;
	localparam logic [sample_width-1:0] mid_code = 9'h000;
	// register byte offsets: two documented, the rest placed in a free block
	localparam logic [7:0] reg_core_source_switch_delay = 8'h9a;
	localparam logic [7:0] reg_mux_select_delay = 8'h9b;
	localparam logic [7:0] reg_cal_control = 8'h80;
	localparam logic [7:0] reg_cal_status = 8'h84;
	localparam logic [7:0] reg_trim_base = 8'hc0;
	localparam logic [7:0] reg_trim_last = 8'hd7;
	// control register fields
	localparam int ctl_background_cal_enable = 0;
	localparam int ctl_trigger_source_select = 1;
	localparam int ctl_software_cal_trigger = 2;
	localparam int ctl_foreground_offset_cal_enable = 3;
	localparam int ctl_background_offset_cal_enable = 4;
	localparam logic [7:0] ctl_reset = 8'h00;
	// status register fields
	localparam int sts_fg_done = 0;
	localparam int sts_busy = 1;
	// variants
	localparam logic [1:0] variant_quad = 2'h0;
	localparam logic [1:0] variant_dual = 2'h1;
	localparam logic [1:0] variant_single = 2'h2;
	// timing: duration of one core calibration pass
	localparam int cal_time_us = 100;
	localparam int clk_mhz = 50;
	localparam int cal_cycles = cal_time_us * clk_mhz;
	localparam logic [7:0] delay_reset = 8'h00;
	localparam logic [7:0] trim_factory_default = 8'h80;
endpackage

// *** src/cal_sequencer.sv ***
// calibration sequencer top: avalon slave, foreground and background calibration
`timescale 1ns/100ps
`default_nettype none
module cal_sequencer #(
	parameter int cal_cycles = cal_pkg::cal_cycles,
	parameter logic [1:0] variant = cal_pkg::variant_quad
) (
	input wire logic clk_sys, // system clock, 50 mhz
	input wire logic reset_n, // synchronous reset, active low
	input wire logic [7:0] avs_address, // byte address
	input wire logic avs_read, // read request
	input wire logic avs_write, // write request
	input wire logic [31:0] avs_writedata, // write data
	input wire logic [3:0] avs_byteenable, // byte enables
	output logic [31:0] avs_readdata, // read data
	output logic avs_waitrequest, // stall
	input wire logic cal_trigger_pin, // external trigger pin, asynchronous
	input wire logic [3:0][8:0] core_sample, // raw samples of cores 0..3 order below
	input wire logic [8:0] core4_sample, // raw sample of core 4
	input wire logic [8:0] core5_sample, // raw sample of core 5
	output logic [3:0][8:0] channel_out, // channel a..d output samples
	output logic [5:0] core_online, // cores in service
	output logic [5:0] core_calibrating, // core under calibration, one hot
	output logic core_use_internal_ref, // calibrating core sees internal reference
	output logic cal_done // foreground calibration finished
);
	typedef enum logic [4:0] {
		st_fg = 5'b00001,
		st_idle = 5'b00010,
		st_bg_cal = 5'b00100,
		st_bg_swap = 5'b01000,
		st_bg_mux = 5'b10000
	} seq_state_t;

	typedef struct packed {
		seq_state_t fsm;
		logic [31:0] cnt;
		logic [7:0] ctl;
		logic [7:0] src_dly;
		logic [7:0] mux_dly;
		logic trig_prev;
		logic [2:0] cal_core; // core being calibrated
		logic [2:0] sub_a; // core replaced by spare 2 (or 6 none)
		logic [2:0] sub_d; // core replaced by spare 3
		logic fg_done;
		logic ack;
		logic [31:0] rdata;
		logic [3:0][8:0] chan;
		logic [5:0] online;
		logic [5:0] calib;
		logic int_ref; // registered reference select
	} top_state_t;
	top_state_t st_q, st_d;

	logic trig_pin_s;
	logic trig_sel;
	logic trig_rise;
	logic [7:0] trim_rdata;
	logic trim_hit;
	logic trim_wr;
	logic [4:0] trim_idx;
	logic [5:0][8:0] raw;

	cal_sync2 u_sync (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.d(cal_trigger_pin),
		.q(trig_pin_s)
	);

	cal_trim_bank u_trim (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.wr_en(trim_wr),
		.idx(trim_idx),
		.wdata(avs_writedata[7:0]),
		.rdata(trim_rdata)
	);

	// one hot of a core number; none for codes above five
	function automatic logic [5:0] core_bit(input logic [2:0] n);
		logic [5:0] r;
		r = 6'h00;
		if (n < 3'd6) begin
			r[n] = 1'b1;
		end
		return r;
	endfunction

	// next core in the rotation of one spare group
	function automatic logic [2:0] next_in_group(input logic [2:0] c, input logic [1:0] v);
		logic [2:0] r;
		r = c;
		unique case (c)
			3'd2: r = 3'd0;
			3'd0: r = (v == cal_pkg::variant_single) ? 3'd2 : 3'd1;
			3'd1: r = 3'd2;
			3'd3: r = 3'd4;
			3'd4: r = 3'd5;
			3'd5: r = 3'd3;
			default: r = 3'd2;
		endcase
		return r;
	endfunction

	// cores fitted on a variant: quad all six, dual 0 to 2, single 0 and 2
	function automatic logic [5:0] fitted_cores(input logic [1:0] v);
		logic [5:0] r;
		r = 6'b000101;
		if (v == cal_pkg::variant_quad) begin
			r = 6'b111111;
		end else if (v == cal_pkg::variant_dual) begin
			r = 6'b000111;
		end
		return r;
	endfunction

	// cores that serve the channels when no spare stands in
	function automatic logic [5:0] home_cores(input logic [1:0] v);
		logic [5:0] r;
		r = 6'b000001;
		if (v == cal_pkg::variant_quad) begin
			r = 6'b110011;
		end else if (v == cal_pkg::variant_dual) begin
			r = 6'b000011;
		end
		return r;
	endfunction

	// settle delay elapsed; a zero delay costs only the state's own cycle
	function automatic logic delay_over(input logic [31:0] c, input logic [7:0] d);
		return c >= 32'(d);
	endfunction

	assign raw = {core5_sample, core4_sample, core_sample[3], core_sample[2], core_sample[1], core_sample[0]};
	// pin or software bit chosen by trigger source select
	assign trig_sel = st_q.ctl[cal_pkg::ctl_trigger_source_select] ? trig_pin_s
		: st_q.ctl[cal_pkg::ctl_software_cal_trigger];
	assign trig_rise = trig_sel && !st_q.trig_prev;
	assign trim_hit = (avs_address >= cal_pkg::reg_trim_base) && (avs_address <= cal_pkg::reg_trim_last);
	assign trim_idx = trim_hit ? 5'(avs_address - cal_pkg::reg_trim_base) : 5'h1f;
	// trim write lands on the answered edge, like every other register
	assign trim_wr = avs_write && trim_hit && avs_byteenable[0] && st_q.ack;

	always_comb begin
		logic [2:0] src;
		logic [2:0] serve;
		logic quad;
		src = 3'd0;
		serve = 3'd0;
		quad = (variant == cal_pkg::variant_quad);
		st_d = st_q;
		st_d.trig_prev = trig_sel;
		// bus slave: one wait cycle then ack for every access
		st_d.ack = (avs_read || avs_write) && !st_q.ack;
		// a write lands on the answered edge only, never while the master is stalled
		if (avs_write && avs_byteenable[0] && st_q.ack) begin
			unique case (avs_address)
				cal_pkg::reg_cal_control: st_d.ctl = {3'h0, avs_writedata[4:0]};
				cal_pkg::reg_core_source_switch_delay: st_d.src_dly = avs_writedata[7:0];
				cal_pkg::reg_mux_select_delay: st_d.mux_dly = avs_writedata[7:0];
				default: ;
			endcase
		end
		if ((avs_read || avs_write) && !st_q.ack) begin
			st_d.rdata = 32'h0000_0000;
			if (avs_read) begin
				unique case (avs_address)
					cal_pkg::reg_cal_control: st_d.rdata = {24'h0, st_q.ctl};
					cal_pkg::reg_cal_status: st_d.rdata = {30'h0, st_q.fsm == st_fg, st_q.fg_done};
					cal_pkg::reg_core_source_switch_delay: st_d.rdata = {24'h0, st_q.src_dly};
					cal_pkg::reg_mux_select_delay: st_d.rdata = {24'h0, st_q.mux_dly};
					default: st_d.rdata = trim_hit ? {24'h0, trim_rdata} : 32'h0000_0000;
				endcase
			end
		end
		// sequencing
		unique case (st_q.fsm)
			st_fg: begin
				st_d.fg_done = 1'b0;
				st_d.online = 6'h00;
				st_d.calib = 6'h00;
				if (st_q.cnt >= 32'(cal_cycles - 1)) begin
					st_d.cnt = 32'h0;
					st_d.fg_done = 1'b1;
					st_d.fsm = st_idle;
				end else begin
					st_d.cnt = st_q.cnt + 32'h1;
				end
			end
			st_idle: begin
				st_d.online = home_cores(variant);
				st_d.calib = 6'h00;
				st_d.sub_a = 3'd6;
				st_d.sub_d = 3'd6;
				if (st_q.ctl[cal_pkg::ctl_background_cal_enable]) begin
					st_d.fsm = st_bg_cal;
					st_d.cal_core = 3'd2; // spare starts calibrating
					st_d.cnt = 32'h0;
				end else if (trig_rise) begin
					st_d.fsm = st_fg;
					st_d.cnt = 32'h0;
				end
			end
			st_bg_cal: begin
				st_d.calib = core_bit(st_q.cal_core);
				if (!st_q.ctl[cal_pkg::ctl_background_cal_enable]) begin
					st_d.fsm = st_idle;
				end else if (st_q.cnt >= 32'(cal_cycles - 1)) begin
					st_d.cnt = 32'h0;
					st_d.fsm = st_bg_swap;
				end else begin
					st_d.cnt = st_q.cnt + 32'h1;
				end
			end
			st_bg_swap: begin
				// calibrated core stays offline until its source switch has settled
				st_d.calib = 6'h00;
				if (!delay_over(st_q.cnt, st_q.src_dly)) begin
					st_d.cnt = st_q.cnt + 32'h1;
				end else begin
					// calibrated core goes into service for the next; output never stops
					st_d.cnt = 32'h0;
					serve = next_in_group(st_q.cal_core, variant);
					if (st_q.cal_core <= 3'd2) begin
						st_d.sub_a = (serve == 3'd2) ? 3'd6 : serve;
					end else begin
						st_d.sub_d = (serve == 3'd3) ? 3'd6 : serve;
					end
					// alternate groups on quad so both spares rotate, one core at a time
					if (quad) begin
						st_d.cal_core = (st_q.cal_core <= 3'd2) ? (st_q.sub_d == 3'd6 ? 3'd3 : st_q.sub_d)
							: (st_q.sub_a == 3'd6 ? 3'd2 : st_q.sub_a);
					end else begin
						st_d.cal_core = serve;
					end
					st_d.fsm = st_bg_mux;
				end
			end
			st_bg_mux: begin
				// channel mux settles on its new source before the next pass starts
				st_d.calib = 6'h00;
				if (delay_over(st_q.cnt, st_q.mux_dly)) begin
					st_d.cnt = 32'h0;
					st_d.fsm = st_bg_cal;
				end else begin
					st_d.cnt = st_q.cnt + 32'h1;
				end
			end
			default: st_d.fsm = st_idle;
		endcase
		// every fitted core but the one under calibration stays active
		if (st_q.fsm == st_bg_cal || st_q.fsm == st_bg_swap || st_q.fsm == st_bg_mux) begin
			st_d.online = fitted_cores(variant) & ~core_bit(st_q.cal_core);
		end
		st_d.int_ref = |st_d.calib;
		// channel mapping: spare stands in for its substituted core
		for (int ch = 0; ch < cal_pkg::num_channels; ch++) begin
			unique case (ch)
				0: src = 3'd0;
				1: src = 3'd1;
				2: src = 3'd4;
				default: src = 3'd5;
			endcase
			if (st_q.sub_a == src) begin
				src = 3'd2;
			end
			if (st_q.sub_d == src) begin
				src = 3'd3;
			end
			if (st_q.fsm == st_fg) begin
				st_d.chan[ch] = cal_pkg::mid_code;
			end else begin
				st_d.chan[ch] = raw[src];
			end
		end
	end

	// reset starts a foreground calibration automatically
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			st_q <= '0;
			st_q.fsm <= st_fg;
			st_q.ctl <= cal_pkg::ctl_reset;
			st_q.src_dly <= cal_pkg::delay_reset;
			st_q.mux_dly <= cal_pkg::delay_reset;
			st_q.sub_a <= 3'd6;
			st_q.sub_d <= 3'd6;
			st_q.cal_core <= 3'd2;
		end else begin
			st_q <= st_d;
		end
	end

	assign avs_readdata = st_q.rdata;
	assign avs_waitrequest = !st_q.ack;
	assign channel_out = st_q.chan;
	assign core_online = st_q.online;
	assign core_calibrating = st_q.calib;
	assign core_use_internal_ref = st_q.int_ref;
	assign cal_done = st_q.fg_done;
endmodule
`default_nettype wire

// *** src/cal_sync2.sv ***
// two flip-flop synchroniser for the calibration trigger pin
`timescale 1ns/100ps
`default_nettype none
module cal_sync2 (
	input wire logic clk_sys, // system clock
	input wire logic reset_n, // synchronous reset, active low
	input wire logic d, // asynchronous level
	output logic q // synchronised level
);
	typedef struct packed {
		logic s1;
		logic s2;
	} sync_state_t;
	sync_state_t st_q, st_d;
	// first stage feeds only the second stage
	always_comb begin
		st_d.s1 = d;
		st_d.s2 = st_q.s1;
	end
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end
	assign q = st_q.s2;
endmodule
`default_nettype wire

// *** src/cal_trim_bank.sv ***
// trim register bank, indexed by kind and core, reset to factory values
`timescale 1ns/100ps
`default_nettype none
module cal_trim_bank #(
	parameter int entries = 24,
	parameter logic [7:0] factory = cal_pkg::trim_factory_default
) (
	input wire logic clk_sys, // system clock
	input wire logic reset_n, // synchronous reset, active low
	input wire logic wr_en, // write strobe
	input wire logic [4:0] idx, // entry index
	input wire logic [7:0] wdata, // write data
	output logic [7:0] rdata // read data of indexed entry
);
	typedef struct packed {
		logic [entries-1:0][7:0] mem;
	} trim_state_t;
	trim_state_t st_q, st_d;
	// factory values are loaded on reset; host may overwrite any entry
	always_comb begin
		st_d = st_q;
		if (wr_en && (int'(idx) < entries)) begin
			st_d.mem[idx] = wdata;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			st_q <= {entries{factory}};
		end else begin
			st_q <= st_d;
		end
	end
	assign rdata = (int'(idx) < entries) ? st_q.mem[idx] : 8'h00;
endmodule
`default_nettype wire

// *** verif/cal_host_model.sv ***
// host side model: trigger pin and dc free core samples
`timescale 1ns/100ps
`default_nettype none
module cal_host_model (
	input wire logic clk_sys, // clock
	input wire logic hold, // freeze samples
	input wire logic fire, // request a pin pulse
	input wire logic [7:0] seed, // sample base
	output logic cal_trigger_pin, // trigger pin
	output logic [3:0][8:0] core_sample, // cores 0..3
	output logic [8:0] core4_sample, // core 4
	output logic [8:0] core5_sample // core 5
);
	logic ph = 1'b0;
	logic [2:0] cnt = 3'h0;
	logic [5:0][8:0] s;
	// sign flips each cycle while hold is low, so no dc content, and never zero
	always_comb begin
		for (int k = 0; k < 6; k++) begin
			s[k] = {1'b0, seed[7:3], 3'(k)} + 9'h001;
			if (ph) s[k] = -s[k];
		end
	end
	assign core_sample = s[3:0];
	assign core4_sample = s[4];
	assign core5_sample = s[5];
	assign cal_trigger_pin = (cnt != 3'h0);
	// pin held four cycles so the synchroniser cannot miss it
	always @(posedge clk_sys) begin
		if (!hold) ph <= !ph;
		if (fire && cnt == 3'h0) cnt <= 3'h4;
		else if (cnt != 3'h0) cnt <= cnt - 3'h1;
	end
endmodule
`default_nettype wire

// *** verif/cal_sequencer_props.sv ***
// assertions on the calibration sequencer ports
`timescale 1ns/100ps
`default_nettype none
module cal_sequencer_props #(
	parameter int cal_cycles = 8,
	parameter logic [1:0] variant = 2'h0
) (
	input wire logic clk_sys, // clock
	input wire logic reset_n, // reset
	input wire logic avs_read, // read
	input wire logic avs_write, // write
	input wire logic avs_waitrequest, // stall
	input wire logic [3:0][8:0] channel_out, // channels
	input wire logic [5:0] core_online, // in service
	input wire logic [5:0] core_calibrating, // calibrating
	input wire logic core_use_internal_ref, // reference select
	input wire logic cal_done // done
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	// active cores during rotation: quad five (one idle core included), dual two, single one
	int n_on;
	assign n_on = (variant == 2'h0) ? 5 : (variant == 2'h1) ? 2 : 1;
	property p_boot; $rose(reset_n) |-> (!cal_done && channel_out == '0) [*6]; endproperty
	a_boot: assert property (p_boot) else $error("startup calibration not seen");
	property p_mid; $fell(cal_done) |=> channel_out == '0; endproperty
	a_mid: assert property (p_mid) else $error("channels not mid-code");
	property p_one; cal_done |-> $onehot0(core_calibrating); endproperty
	a_one: assert property (p_one) else $error("more than one core calibrating");
	property p_ref; core_use_internal_ref == (core_calibrating != 6'h00); endproperty
	a_ref: assert property (p_ref) else $error("reference select wrong");
	property p_off; (core_calibrating & core_online) == 6'h00; endproperty
	a_off: assert property (p_off) else $error("calibrating core in service");
	property p_cnt; cal_done && core_calibrating != 6'h00 |-> $countones(core_online) == n_on; endproperty
	a_cnt: assert property (p_cnt) else $error("wrong number of cores in service");
	property p_ack; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
	a_ack: assert property (p_ack) else $error("bus answer late");
	property p_pulse; !avs_waitrequest |=> avs_waitrequest; endproperty
	a_pulse: assert property (p_pulse) else $error("answer held too long");
	property p_idle; !(avs_read || avs_write) |=> avs_waitrequest; endproperty
	a_idle: assert property (p_idle) else $error("answer without request");
	c_fg: cover property ($fell(cal_done));
	c_bg: cover property (cal_done && core_calibrating != 6'h00);
	c_rd: cover property (avs_read && !avs_waitrequest);
endmodule
bind cal_sequencer cal_sequencer_props #(.cal_cycles(cal_cycles), .variant(variant)) chk (.clk_sys, .reset_n,
	.avs_read, .avs_write, .avs_waitrequest, .channel_out, .core_online, .core_calibrating,
	.core_use_internal_ref, .cal_done);
`default_nettype wire

// *** verif/cal_sequencer_tb.sv ***
// self-checking bench of the calibration sequencer
`timescale 1ns/100ps
`default_nettype none
module cal_sequencer_tb;
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'h1;
	logic [31:0] avs_readdata;
	logic avs_waitrequest, cal_trigger_pin, cal_done, core_use_internal_ref, gap;
	logic [3:0][8:0] core_sample, channel_out, src;
	logic [8:0] core4_sample, core5_sample;
	logic [5:0] core_online, core_calibrating, seen;
	logic hold = 1'b1;
	logic fire = 1'b0;
	logic [7:0] rnd = 8'h56;
	logic [7:0] ta;
	logic [31:0] exp_q[$];
	int failures = 0;
	int comparisons = 0;
	int cycles = 0;
	always #10 clk_sys = ~clk_sys;
	cal_sequencer #(.cal_cycles(8)) uut (.clk_sys, .reset_n, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .cal_trigger_pin, .core_sample,
		.core4_sample, .core5_sample, .channel_out, .core_online, .core_calibrating, .core_use_internal_ref, .cal_done);
	cal_host_model partner (.clk_sys, .hold, .fire, .seed(rnd), .cal_trigger_pin, .core_sample,
		.core4_sample, .core5_sample);
	function automatic logic [7:0] lfsr(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	task automatic check(input string nm, input logic [31:0] got, input logic [31:0] want);
		comparisons++;
		if (got !== want) begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, want, got);
		end
	endtask
	task automatic wrap_up;
		$display("failures %0d comparisons %0d", failures, comparisons);
		if (failures == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// one bus access; a read leaves its expected value for the monitor
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
		if (!w) exp_q.push_back(e);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		// wait ends when waitrequest drops; only the bench timeout ends a hang
		do begin
			@(posedge clk_sys);
		end while (avs_waitrequest !== 1'b0);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic wait_done(input logic v);
		int n;
		n = 0;
		while (cal_done !== v && n < 40) begin
			@(posedge clk_sys);
			n++;
		end
		check("cal_done", 32'(cal_done), 32'(v));
	endtask
	// read answers are compared at the edge where they stand
	always @(posedge clk_sys) begin
		if (reset_n && avs_read && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
			check("readdata", avs_readdata, exp_q.pop_front());
		end
	end
	// a hang ends the run instead of stalling it
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 4000) begin
			failures++;
			wrap_up();
		end
	end
	initial begin
		repeat (3) @(posedge clk_sys);
		reset_n <= 1'b1;
		@(posedge clk_sys);
		bus(1'b0, cal_pkg::reg_cal_status, 32'h0, 32'h2);
		wait_done(1'b1);
		bus(1'b0, cal_pkg::reg_cal_status, 32'h0, 32'h1);
		bus(1'b0, cal_pkg::reg_core_source_switch_delay, 32'h0, 32'h0);
		bus(1'b1, cal_pkg::reg_core_source_switch_delay, 32'h1f, 32'h0);
		bus(1'b1, cal_pkg::reg_mux_select_delay, 32'h1e, 32'h0);
		bus(1'b0, cal_pkg::reg_core_source_switch_delay, 32'h0, 32'h1f);
		bus(1'b0, cal_pkg::reg_mux_select_delay, 32'h0, 32'h1e);
		rnd <= lfsr(rnd);
		@(posedge clk_sys);
		ta = cal_pkg::reg_trim_base + {4'h0, rnd[3:0]};
		bus(1'b0, ta, 32'h0, 32'h80);
		bus(1'b1, ta, {24'h0, rnd}, 32'h0);
		bus(1'b0, ta, 32'h0, {24'h0, rnd});
		bus(1'b0, cal_pkg::reg_trim_last, 32'h0, 32'h80);
		bus(1'b0, 8'h10, 32'h0, 32'h0);
		repeat (3) @(posedge clk_sys);
		src = {core5_sample, core4_sample, core_sample[1], core_sample[0]};
		for (int k = 0; k < 4; k++) check("channel", 32'(channel_out[k]), 32'(src[k]));
		check("online", 32'(core_online), 32'h0000_0033);
		bus(1'b1, cal_pkg::reg_cal_control, 32'h2, 32'h0);
		fire <= 1'b1;
		@(posedge clk_sys);
		fire <= 1'b0;
		wait_done(1'b0);
		wait_done(1'b1);
		bus(1'b1, cal_pkg::reg_cal_control, 32'h4, 32'h0);
		wait_done(1'b0);
		@(posedge clk_sys);
		for (int k = 0; k < 4; k++) check("mid", 32'(channel_out[k]), 32'h0000_0000);
		wait_done(1'b1);
		hold <= 1'b0;
		bus(1'b1, cal_pkg::reg_cal_control, 32'h5, 32'h0);
		seen = 6'h00;
		gap = 1'b0;
		// each pass with the programmed settle delays takes about 71 cycles
		repeat (600) begin
			@(posedge clk_sys);
			seen = seen | core_calibrating;
			for (int k = 0; k < 4; k++) if (channel_out[k] === 9'h000) gap = 1'b1;
		end
		check("rotation", 32'(seen), 32'h0000_003f);
		check("gap", 32'(gap), 32'h0000_0000);
		wrap_up();
	end
endmodule
`default_nettype wire
